// ==== ddsl_loader.sv ====
// serial input and double-buffered channel registers of a dual converter
`timescale 1ns/100ps
// Function
// - a full update is fourteen shifted bits
// - first two bits are address, high first
// - then twelve code bits, msb first
// - code is unsigned straight binary
// - address selects both, a only, b only
// - shifting leaves channels alone while strobe high
// - falling strobe copies shift register into channels
// - channels follow shift register while strobe low
// - bits shifted with strobe low reach outputs
// - shift only with select low; else hold
// - serial data sampled on rising serial clock
// - transparency ignores select and serial clock
module ddsl_loader
    import ddsl_pkg::*;
#(
    parameter int WORD_W = WORD_BITS,
    parameter int CODE_W = CODE_BITS,
    parameter int DEPTH  = FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // serial pins from the host
    input  wire logic              serial_clk,
    input  wire logic              serial_in,
    input  wire logic              chip_sel_n,
    input  wire logic              latch_update_n,
    // converter codes
    output logic      [CODE_W-1:0] chan_a_code,
    output logic      [CODE_W-1:0] chan_b_code,
    // word stream taken at each strobe fall
    output logic                   word_valid,
    input  wire logic              word_ready,
    output logic      [WORD_W-1:0] word_data,
    // shift register view
    output logic      [WORD_W-1:0] shift_word,
    output logic                   word_complete
);

    typedef struct packed
    {
        logic [WORD_W-1:0] shift;
        logic [4:0]        bit_cnt;
        logic              sclk_prev;
        logic              load_prev;
        logic [CODE_W-1:0] code_a;
        logic [CODE_W-1:0] code_b;
        logic              cap_valid;
        logic [WORD_W-1:0] cap_word;
    } ddsl_state_t;

    ddsl_state_t       state_q;
    ddsl_state_t       state_d;
    logic [3:0]        pins_s;
    logic              sclk_s;
    logic              sdi_s;
    logic              cs_n_s;
    logic              load_n_s;
    logic              shift_en;
    logic              load_fall;
    logic              fifo_in_ready;
    logic [WORD_W-1:0] live_word;
    logic [1:0]        live_hits;

    initial
    begin
        if (WORD_W != WORD_BITS || CODE_W != CODE_BITS)
            $error("ddsl_loader: word layout is fixed at 2 address + 12 code bits");
    end

    // which channels a word addresses
    function automatic logic [1:0] chan_hits(input logic [WORD_W-1:0] w);
        logic [1:0] sel;
        sel = {w[ADDR_HI_POS], w[ADDR_LO_POS]};
        case (sel)
            DDSL_TGT_A: chan_hits = 2'b01;
            DDSL_TGT_B: chan_hits = 2'b10;
            default:    chan_hits = 2'b11;
        endcase
    endfunction

    // pins are idle-high except the serial lines
    ddsl_sync #(
        .WIDTH (4),
        .INIT  (4'b0011)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in ({serial_clk, serial_in, chip_sel_n, latch_update_n}),
        .sync_out (pins_s)
    );

    assign sclk_s   = pins_s[3];
    assign sdi_s    = pins_s[2];
    assign cs_n_s   = pins_s[1];
    assign load_n_s = pins_s[0];

    // data and clock share synchroniser delay, so setup holds if clock low > 2 cycles
    assign shift_en  = sclk_s && !state_q.sclk_prev && !cs_n_s;
    assign load_fall = !load_n_s && state_q.load_prev;

    // the transparent view includes the bit arriving this cycle
    assign live_word = shift_en ? {state_q.shift[WORD_W-2:0], sdi_s} : state_q.shift;
    assign live_hits = chan_hits(live_word);

    always_comb
    begin
        state_d           = state_q;
        state_d.sclk_prev = sclk_s;
        state_d.load_prev = load_n_s;
        if (shift_en)
        begin
            // oldest bit falls off the top
            state_d.shift = live_word;
            if (state_q.bit_cnt != 5'(WORD_W))
                state_d.bit_cnt = state_q.bit_cnt + 5'd1;
        end
        // strobe high: channels hold regardless of shifting
        if (!load_n_s)
        begin
            // straight binary, passed through unchanged
            if (live_hits[0])
                state_d.code_a = live_word[CODE_W-1:0];
            if (live_hits[1])
                state_d.code_b = live_word[CODE_W-1:0];
        end
        if (fifo_in_ready)
            state_d.cap_valid = 1'b0;
        // new capture wins; a capture still waiting for fifo room is overwritten and dropped
        if (load_fall)
        begin
            state_d.cap_valid = 1'b1;
            state_d.cap_word  = live_word;
            state_d.bit_cnt   = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_q           <= '0;
            state_q.shift     <= SHIFT_RESET;
            state_q.sclk_prev <= 1'b0;
            state_q.load_prev <= 1'b1;
            state_q.code_a    <= CODE_RESET;
            state_q.code_b    <= CODE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    ddsl_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (state_q.cap_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (state_q.cap_word),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );

    assign chan_a_code   = state_q.code_a;
    assign chan_b_code   = state_q.code_b;
    assign shift_word    = state_q.shift;
    assign word_complete = (state_q.bit_cnt == 5'(WORD_W));

endmodule

// ==== ddsl_pkg.sv ====
// shared constants and types of the dual converter serial loader
package ddsl_pkg;

    localparam int WORD_BITS     = 14;
    localparam int CODE_BITS     = 12;
    localparam int ADDR_HI_POS   = 13;
    localparam int ADDR_LO_POS   = 12;
    localparam int FIFO_DEPTH    = 16;
    localparam int SYNC_STAGES   = 2;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [13:0] SHIFT_RESET = 14'h0000;
    localparam logic [11:0] CODE_ZERO_SCALE = 12'h000;
    localparam logic [11:0] CODE_FULL_SCALE = 12'hFFF;

    // which channel registers a word reaches
    typedef enum logic [1:0]
    {
        DDSL_TGT_BOTH = 2'b00,
        DDSL_TGT_A    = 2'b10,
        DDSL_TGT_B    = 2'b11
    } ddsl_target_t;

endpackage

// ==== ddsl_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ddsl_sync
    import ddsl_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // pins and synchronised copies
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ddsl_sync_state_t;

    ddsl_sync_state_t state_q;
    ddsl_sync_state_t state_d;

    initial
    begin
        if (WIDTH < 1)
            $error("ddsl_sync: WIDTH must be at least 1");
    end

    always_comb
    begin
        state_d        = state_q;
        state_d.meta   = async_in;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            state_q <= {INIT, INIT};
        else
            state_q <= state_d;
    end

    assign sync_out = state_q.stable;

endmodule

// ==== ddsl_fifo.sv ====
// word fifo with valid/ready on both sides
`timescale 1ns/100ps
module ddsl_fifo
    import ddsl_pkg::*;
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed
    {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } ddsl_fifo_state_t;

    ddsl_fifo_state_t state_q;
    ddsl_fifo_state_t state_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("ddsl_fifo: DEPTH must be a power of two, at least 2");
        if (WIDTH < 1)
            $error("ddsl_fifo: WIDTH must be at least 1");
    end

    assign in_ready  = (state_q.count != (AW + 1)'(DEPTH));
    assign out_valid = (state_q.count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[state_q.rd_ptr];

    always_comb
    begin
        state_d = state_q;
        if (push)
            state_d.wr_ptr = state_q.wr_ptr + 1'b1;
        if (pop)
            state_d.rd_ptr = state_q.rd_ptr + 1'b1;
        case ({push, pop})
            2'b10:   state_d.count = state_q.count + 1'b1;
            2'b01:   state_d.count = state_q.count - 1'b1;
            default: state_d.count = state_q.count;
        endcase
    end

    // storage needs no reset; only the count and pointers define what is valid
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[state_q.wr_ptr] <= in_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            state_q <= '0;
        else
            state_q <= state_d;
    end

endmodule

// ==== ddsl_sva.sv ====
// assertions on the serial loader ports
`timescale 1ns/100ps
module ddsl_sva
    import ddsl_pkg::*;
#(
    parameter int WORD_W = WORD_BITS,
    parameter int CODE_W = CODE_BITS,
    parameter int DEPTH  = FIFO_DEPTH
)
(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              rstn,
    // pins
    input wire logic              serial_clk,
    input wire logic              serial_in,
    input wire logic              chip_sel_n,
    input wire logic              latch_update_n,
    // outputs, plus the word_ready input
    input wire logic [CODE_W-1:0] chan_a_code,
    input wire logic [CODE_W-1:0] chan_b_code,
    input wire logic              word_valid,
    input wire logic              word_ready,
    input wire logic [WORD_W-1:0] word_data,
    input wire logic [WORD_W-1:0] shift_word,
    input wire logic              word_complete
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // five samples cover the two synchroniser stages plus margin
    property p_hold;
        latch_update_n [*5] |=> $stable(chan_a_code) && $stable(chan_b_code);
    endproperty
    a_hold: assert property (p_hold) else $error("codes moved");
    property p_desel;
        chip_sel_n [*5] |=> $stable(shift_word);
    endproperty
    a_desel: assert property (p_desel) else $error("shift moved");
    property p_shift;
        $rose(serial_clk) && !chip_sel_n
            |-> ##4 shift_word == {$past(shift_word[12:0], 4), $past(serial_in, 4)};
    endproperty
    a_shift: assert property (p_shift) else $error("bad shift");
    sequence s_low;
        !latch_update_n [*5];
    endsequence
    property p_fol_a;
        s_low ##0 shift_word[13:12] == 2'b10 |-> chan_a_code == shift_word[11:0];
    endproperty
    a_fol_a: assert property (p_fol_a) else $error("a not live");
    property p_fol_b;
        s_low ##0 shift_word[13:12] == 2'b11 |-> chan_b_code == shift_word[11:0];
    endproperty
    a_fol_b: assert property (p_fol_b) else $error("b not live");
    property p_both;
        s_low ##0 !shift_word[13] |-> {chan_a_code, chan_b_code} == {2{shift_word[11:0]}};
    endproperty
    a_both: assert property (p_both) else $error("both not live");
    property p_a_only;
        s_low ##0 shift_word[13:12] == 2'b10 |-> $stable(chan_b_code);
    endproperty
    a_a_only: assert property (p_a_only) else $error("b touched");
    property p_capt;
        $fell(latch_update_n) |-> ##[3:6] word_valid;
    endproperty
    a_capt: assert property (p_capt) else $error("no capture");
    c_live: cover property (!latch_update_n && !chip_sel_n && $rose(serial_clk));
    c_stall: cover property (word_valid && !word_ready);
    c_pop: cover property (word_valid && word_ready && word_complete);
endmodule
bind ddsl_loader ddsl_sva #(.WORD_W(WORD_W), .CODE_W(CODE_W), .DEPTH(DEPTH)) ddsl_sva_inst (
    .sys_clk(sys_clk), .rstn(rstn), .serial_clk(serial_clk), .serial_in(serial_in),
    .chip_sel_n(chip_sel_n), .latch_update_n(latch_update_n), .chan_a_code(chan_a_code),
    .chan_b_code(chan_b_code), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .shift_word(shift_word), .word_complete(word_complete));

// ==== ddsl_host.sv ====
// host model driving the serial pins
`timescale 1ns/100ps
module ddsl_host
(
    // pacing clock
    input  wire logic sys_clk,
    // serial pins
    output logic      serial_clk,
    output logic      serial_in,
    output logic      chip_sel_n,
    output logic      latch_update_n
);
    initial
    begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        chip_sel_n = 1'b1;
        latch_update_n = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // 320 ns serial clock, still between frames
    task automatic send(input logic [13:0] w, input logic sel_n);
        chip_sel_n = sel_n;
        for (int i = 13; i >= 0; i--)
        begin
            wait_n(4);
            serial_clk = 1'b0;
            serial_in = w[i];
            wait_n(4);
            serial_clk = 1'b1;
        end
        wait_n(4);
        serial_clk = 1'b0;
        wait_n(4);
        chip_sel_n = 1'b1;
        // no stale level after release
        serial_in = ~w[0];
        // keeps select high at least briefly between frames
        wait_n(2);
    endtask
    // select stays high around the strobe
    task automatic strobe(input logic v);
        chip_sel_n = 1'b1;
        latch_update_n = v;
        wait_n(6);
    endtask
endmodule

// ==== ddsl_loader_tb.sv ====
// self-checking bench for the serial loader
`timescale 1ns/100ps
module ddsl_loader_tb;
    import ddsl_pkg::*;
    logic        sys_clk;
    logic        rstn;
    logic        word_ready;
    logic        serial_clk;
    logic        serial_in;
    logic        chip_sel_n;
    logic        latch_update_n;
    logic [11:0] chan_a_code;
    logic [11:0] chan_b_code;
    logic        word_valid;
    logic [13:0] word_data;
    logic [13:0] shift_word;
    logic        word_complete;
    int          mismatches = 0;
    int          tests_run = 0;
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    ddsl_host ddsl_host_inst (.sys_clk(sys_clk), .serial_clk(serial_clk), .serial_in(serial_in),
        .chip_sel_n(chip_sel_n), .latch_update_n(latch_update_n));
    ddsl_loader ddsl_loader_inst (.sys_clk(sys_clk), .rstn(rstn), .serial_clk(serial_clk),
        .serial_in(serial_in), .chip_sel_n(chip_sel_n), .latch_update_n(latch_update_n),
        .chan_a_code(chan_a_code), .chan_b_code(chan_b_code), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data), .shift_word(shift_word),
        .word_complete(word_complete));
    task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // seventeenth capture waits in the capture slot until the fifo has room
    task automatic t_fifo();
        for (int i = 0; i < 17; i++)
        begin
            ddsl_host_inst.send(14'h2000 + 14'(i), 1'b0);
            ddsl_host_inst.strobe(1'b0);
            ddsl_host_inst.strobe(1'b1);
        end
        check("fifo full", word_valid, 1'b1);
        for (int i = 0; i < 17; i++)
        begin
            check("fifo word", word_data, 14'h2000 + 14'(i));
            word_ready = 1'b1;
            @(negedge sys_clk);
        end
        word_ready = 1'b0;
        check("fifo empty", word_valid, 1'b0);
    endtask
    task automatic t_addr();
        logic [13:0] w [4] = '{14'h0FFF, 14'h2801, 14'h3000, 14'h17FF};
        logic [11:0] ea;
        logic [11:0] eb;
        // last fifo word went to channel a only; b still holds its reset code
        ea = 12'h010;
        eb = CODE_RESET;
        foreach (w[i])
        begin
            ddsl_host_inst.send(w[i], 1'b0);
            check("shift", shift_word, w[i]);
            check("complete", word_complete, 1'b1);
            check("a held", chan_a_code, ea);
            check("b held", chan_b_code, eb);
            ddsl_host_inst.strobe(1'b0);
            ddsl_host_inst.strobe(1'b1);
            check("complete clr", word_complete, 1'b0);
            if (!w[i][13] || !w[i][12])
                ea = w[i][11:0];
            if (!w[i][13] || w[i][12])
                eb = w[i][11:0];
            check("a code", chan_a_code, ea);
            check("b code", chan_b_code, eb);
        end
    endtask
    task automatic t_live();
        ddsl_host_inst.strobe(1'b0);
        ddsl_host_inst.send(14'h2555, 1'b0);
        check("a live", chan_a_code, 12'h555);
        ddsl_host_inst.strobe(1'b1);
    endtask
    task automatic t_cs();
        ddsl_host_inst.send(14'h1234, 1'b0);
        ddsl_host_inst.send(14'h2ABC, 1'b1);
        check("deselected", shift_word, 14'h1234);
        check("a kept", chan_a_code, 12'h555);
        ddsl_host_inst.send(14'h3C3C, 1'b0);
        check("latest", shift_word, 14'h3C3C);
        check("first capture", word_data, 14'h0FFF);
        word_ready = 1'b1;
        @(negedge sys_clk);
        word_ready = 1'b0;
        check("next capture", word_data, 14'h2801);
    endtask
    // reset in mid-run clears codes, shift register and queued words
    task automatic t_reset();
        rstn = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("rst a", chan_a_code, CODE_RESET);
        check("rst b", chan_b_code, CODE_RESET);
        check("rst shift", shift_word, SHIFT_RESET);
        check("rst valid", word_valid, 1'b0);
        check("rst complete", word_complete, 1'b0);
    endtask
    initial
    begin
        rstn = 1'b0;
        word_ready = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("reset valid", word_valid, 1'b0);
        t_fifo();
        t_addr();
        t_live();
        t_cs();
        t_reset();
        give_verdict();
    end
    initial
    begin
        #1_000_000;
        mismatches++;
        give_verdict();
    end
endmodule
